// [csl_params.svh]
`ifndef CSL_PARAMS_SVH
`define CSL_PARAMS_SVH

// Voltage ceilings in mV and steps
`define CSL_V_REF_MV        16'h09A1  // 2465 mV
`define CSL_V_CEIL0_MV      16'h20F0  // 8432 mV
`define CSL_V_CEIL1_MV      16'h3160  // 12640 mV
`define CSL_V_CEIL2_MV      16'h41E0  // 16864 mV
`define CSL_V_CEIL3_MV      16'h5240  // 21056 mV
`define CSL_V_CEIL4_MV      16'h8000  // 32768 mV
`define CSL_V_FINE_STEP     16'h0010  // 16 mV
`define CSL_V_COARSE_STEP   16'h0020  // 32 mV
// Current full scales in mA
`define CSL_I_FS0_MA        16'h03FF  // 1023 mA
`define CSL_I_FS1_MA        16'h07FE  // 2046 mA
`define CSL_I_FS2_MA        16'h0FFC  // 4092 mA
`define CSL_I_FS3_MA        16'h1FF8  // 8184 mA
`define CSL_I_WAKE_MA       16'h0050  // 80 mA
// Modulator scaling: normal-mode duty = 80 percent of request/full scale
`define CSL_DUTY_NUM        32'h00000004
`define CSL_DUTY_DEN        32'h00000005
`define CSL_LOW_SHIFT       4
// Low-current PWM: one of 8 fast slots high
`define CSL_PWM_SLOTS       3'h7
// Slow modulator step
`define CSL_CLK_HZ          50000000
`define CSL_SLOW_STEP_MS    45
`define CSL_SLOW_CYCLES     ((`CSL_CLK_HZ / 1000) * `CSL_SLOW_STEP_MS)
`endif

// [csl_pkg.sv]
package csl_pkg;
  typedef enum logic [1:0] {
    CSL_CHG_RESET      = 2'b00,
    CSL_CHG_WAKE       = 2'b01,
    CSL_CHG_CONTROLLED = 2'b10,
    CSL_CHG_NONE       = 2'b11
  } csl_chg_state_e;

  // Analog comparator results
  typedef struct packed {
    logic [2:0] ilim_cmp;   // Thermometer code from current selector
    logic [3:0] vlim_cmp;   // Thermometer code from voltage selector
    logic       batt_hi;    // Battery above 89 percent of adapter
    logic       batt_lo;    // Battery below 87 percent of adapter
  } csl_cmp_s;

  // Set-point results
  typedef struct packed {
    logic [15:0] volt_dac;
    logic        volt_overrange;
    logic        low_current_mode;
    logic        current_scale_gate;
  } csl_out_s;
endpackage : csl_pkg

// [csl_limiter.sv]
`timescale 1ns/1ps
`include "csl_params.svh"
module csl_limiter
  import csl_pkg::*;
#(
  parameter int unsigned SLOW_CYCLES = `CSL_SLOW_CYCLES
) (
  input  wire logic           clk_i,
  input  wire logic           nrst_i,
  input  wire csl_cmp_s       cmp_i,
  input  wire logic           adapter_present_flag_i,
  input  wire csl_chg_state_e chg_state_i,
  input  wire logic           inhibit_charge_i,
  input  wire logic           wakeup_i,
  input  wire logic           volt_wr_i,
  input  wire logic [15:0]    requested_voltage_cmd_i,
  input  wire logic           curr_wr_i,
  input  wire logic [15:0]    requested_current_cmd_i,
  output csl_out_s            dac_o,
  output logic [1:0]          current_range_select_o,
  output logic [2:0]          voltage_range_select_o,
  output logic                battery_over_input_flag_o,
  output logic                charge_enable_out_o
);

  // Count of set bits in a thermometer code
  function automatic logic [2:0] therm_count(input logic [3:0] t);
    therm_count = 3'(t[0]) + 3'(t[1]) + 3'(t[2]) + 3'(t[3]);
  endfunction : therm_count

  function automatic logic [15:0] i_full_scale(input logic [1:0] sel);
    case (sel)
      2'h0:    i_full_scale = `CSL_I_FS0_MA;
      2'h1:    i_full_scale = `CSL_I_FS1_MA;
      2'h2:    i_full_scale = `CSL_I_FS2_MA;
      default: i_full_scale = `CSL_I_FS3_MA;
    endcase
  endfunction : i_full_scale

  function automatic logic [15:0] v_ceiling(input logic [2:0] sel);
    case (sel)
      3'h0:    v_ceiling = `CSL_V_CEIL0_MV;
      3'h1:    v_ceiling = `CSL_V_CEIL1_MV;
      3'h2:    v_ceiling = `CSL_V_CEIL2_MV;
      3'h3:    v_ceiling = `CSL_V_CEIL3_MV;
      default: v_ceiling = `CSL_V_CEIL4_MV;
    endcase
  endfunction : v_ceiling

  logic [1:0]  cur_sel;
  logic [2:0]  vol_sel;
  logic [15:0] volt_req;
  logic [15:0] curr_req;
  logic [15:0] next_volt_dac;
  logic        next_over;
  logic [15:0] i_fs;
  logic [15:0] v_step;
  logic [15:0] i_code;
  logic [15:0] mod_target;
  logic [16:0] accum;
  logic        ds_bit;
  logic        low_mode;
  logic [2:0]  pwm_slot;
  logic [31:0] slow_cnt;
  logic        ds_step;
  logic [15:0] volt_code;
  logic        volt_over;
  logic        low_current;
  logic        scale_gate;

  // Range decode from comparator ladders; the range is the count of set bits, so a gap or glitch still counts every high bit
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cur_sel <= 2'h0;
      vol_sel <= 3'h0;
    end else begin
      cur_sel <= 2'(therm_count({1'b0, cmp_i.ilim_cmp}));
      vol_sel <= therm_count(cmp_i.vlim_cmp);
    end
  end
  assign current_range_select_o = cur_sel;
  assign voltage_range_select_o = vol_sel;

  // Capture requests; they reach the DAC paths one clock later
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      volt_req <= 16'h0000;
      curr_req <= 16'h0000;
    end else begin
      if (volt_wr_i) volt_req <= requested_voltage_cmd_i;
      if (curr_wr_i) curr_req <= requested_current_cmd_i;
    end
  end

  // Voltage path: offset, floor, ceiling, step quantise
  always_comb begin
    v_step = (vol_sel < 3'h2) ? `CSL_V_FINE_STEP : `CSL_V_COARSE_STEP;
    next_over = 1'b0;
    if (volt_req < `CSL_V_REF_MV) begin
      next_volt_dac = 16'h0000;
    end else if (volt_req > v_ceiling(vol_sel)) begin
      next_volt_dac = v_ceiling(vol_sel) - `CSL_V_REF_MV;
      next_over = 1'b1;
    end else begin
      next_volt_dac = volt_req - `CSL_V_REF_MV;
    end
    next_volt_dac = next_volt_dac & ~(v_step - 16'h0001);
  end

  // Registered voltage set-point; overrange is a level that follows the clamp
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      volt_code <= 16'h0000;
      volt_over <= 1'b0;
    end else begin
      volt_code <= next_volt_dac;
      volt_over <= next_over;
    end
  end

  // Current request clamped to range, wake-up code overrides
  always_comb begin
    i_fs = i_full_scale(cur_sel);
    if (wakeup_i) begin
      i_code = `CSL_I_WAKE_MA;
    end else if (curr_req > i_fs) begin
      i_code = i_fs;
    end else begin
      i_code = curr_req;
    end
    // Granularity of the range
    i_code = (i_code >> cur_sel) << cur_sel;
    low_mode = (i_code < (i_fs >> `CSL_LOW_SHIFT));
    // Normal mode scales to 80 percent duty; low mode gates full 1/8 pulses
    if (low_mode) begin
      mod_target = i_code;
    end else begin
      mod_target = 16'((32'(i_code) * `CSL_DUTY_NUM) / `CSL_DUTY_DEN);
    end
  end

  // Slow step enable for low-current mode
  always_ff @(posedge clk_i) begin
    if (!nrst_i || !low_mode) begin
      slow_cnt <= 32'h0000_0000;
    end else if (slow_cnt == SLOW_CYCLES - 1) begin
      slow_cnt <= 32'h0000_0000;
    end else begin
      slow_cnt <= slow_cnt + 32'h0000_0001;
    end
  end
  assign ds_step = !low_mode || (slow_cnt == SLOW_CYCLES - 1);

  // First-order delta-sigma against full scale; low mode uses fs/8 per on bit
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      accum  <= 17'h00000;
      ds_bit <= 1'b0;
    end else if (ds_step) begin
      if ({1'b0, accum[15:0]} + {1'b0, mod_target} >=
          {1'b0, low_mode ? (i_fs >> 3) : i_fs}) begin
        accum  <= 17'({1'b0, accum[15:0]} + {1'b0, mod_target}
                  - {1'b0, low_mode ? (i_fs >> 3) : i_fs});
        ds_bit <= 1'b1;
      end else begin
        accum  <= 17'({1'b0, accum[15:0]} + {1'b0, mod_target});
        ds_bit <= 1'b0;
      end
    end
  end

  // Fast 1/8 duty PWM slot counter
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pwm_slot <= 3'h0;
    end else begin
      pwm_slot <= pwm_slot + 3'h1;
    end
  end

  // Registered mode and gate; in low mode only one fast slot in eight can pass
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      scale_gate  <= 1'b0;
      low_current <= 1'b0;
    end else begin
      low_current <= low_mode;
      scale_gate  <= low_mode ? (ds_bit && pwm_slot == `CSL_PWM_SLOTS)
                              : ds_bit;
    end
  end

  // Pack the set-points; each field keeps a single clocked driver
  assign dac_o = '{volt_dac:           volt_code,
                   volt_overrange:     volt_over,
                   low_current_mode:   low_current,
                   current_scale_gate: scale_gate};

  // Power-fail flag with hysteresis; adapter absent wins
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      battery_over_input_flag_o <= 1'b0;
    end else if (!adapter_present_flag_i) begin
      battery_over_input_flag_o <= 1'b0;
    end else if (cmp_i.batt_hi) begin
      battery_over_input_flag_o <= 1'b1;
    end else if (cmp_i.batt_lo) begin
      battery_over_input_flag_o <= 1'b0;
    end
  end

  // Charge enable per charger state
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      charge_enable_out_o <= 1'b0;
    end else begin
      case (chg_state_i)
        CSL_CHG_WAKE:       charge_enable_out_o <= !inhibit_charge_i;
        CSL_CHG_CONTROLLED: charge_enable_out_o <= !inhibit_charge_i &&
                                                   (volt_req != 16'h0000);
        default:            charge_enable_out_o <= 1'b0;
      endcase
    end
  end
endmodule : csl_limiter

// [csl_limiter_properties.sv]
`timescale 1ns/1ps
module csl_chk
  import csl_pkg::*;
(
  input wire logic           clk_i,
  input wire logic           nrst_i,
  input wire csl_cmp_s       cmp_i,
  input wire logic           adapter_present_flag_i,
  input wire csl_chg_state_e chg_state_i,
  input wire logic           inhibit_charge_i,
  input wire logic           volt_wr_i,
  input wire logic [15:0]    requested_voltage_cmd_i,
  input wire csl_out_s       dac_o,
  input wire logic [1:0]     current_range_select_o,
  input wire logic [2:0]     voltage_range_select_o,
  input wire logic           battery_over_input_flag_o,
  input wire logic           charge_enable_out_o
);
  logic run;
  // Skip the release edge so $past never looks at inputs from inside reset
  always_ff @(posedge clk_i) run <= nrst_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_pf_absent: assert property (!adapter_present_flag_i |=> !battery_over_input_flag_o)
    else $error("flag high without adapter");
  a_pf_set: assert property (adapter_present_flag_i && cmp_i.batt_hi
    |=> battery_over_input_flag_o) else $error("flag not set on high battery");
  a_wake_enable: assert property (run && chg_state_i == CSL_CHG_WAKE |=>
    charge_enable_out_o == !$past(inhibit_charge_i)) else $error("wake enable wrong");
  a_vrange_decode: assert property (run |=>
    voltage_range_select_o == 3'($past($countones(cmp_i.vlim_cmp)))) else $error("vrange wrong");
  a_irange_decode: assert property (run |=>
    current_range_select_o == 2'($past($countones(cmp_i.ilim_cmp)))) else $error("irange wrong");
  a_below_ref: assert property (volt_wr_i && requested_voltage_cmd_i < 16'h09A1
    ##1 !volt_wr_i |-> ##2 dac_o.volt_dac == 16'h0000 && !dac_o.volt_overrange)
    else $error("below ref not 0");
  a_over_flag: assert property (volt_wr_i && requested_voltage_cmd_i > 16'h8000
    ##1 !volt_wr_i |-> ##2 dac_o.volt_overrange) else $error("overrange not flagged");
  a_gate_pulse: assert property (dac_o.low_current_mode && dac_o.current_scale_gate |=>
    !dac_o.current_scale_gate || !dac_o.low_current_mode) else $error("low mode gate too wide");
  a_top_ceiling: assert property (dac_o.volt_dac <= 16'h765F)
    else $error("voltage above widest ceiling");
  c_low: cover property (dac_o.low_current_mode);
  c_over: cover property (dac_o.volt_overrange);
  c_pf: cover property (battery_over_input_flag_o);
endmodule : csl_chk
bind csl_limiter csl_chk chk_u (.clk_i, .nrst_i, .cmp_i, .adapter_present_flag_i, .chg_state_i,
  .inhibit_charge_i, .volt_wr_i, .requested_voltage_cmd_i, .dac_o, .current_range_select_o,
  .voltage_range_select_o, .battery_over_input_flag_o, .charge_enable_out_o);

// [csl_analog_model.sv]
`timescale 1ns/1ps
module csl_analog_model
  import csl_pkg::*;
(
  input  wire logic [1:0]  i_range_i,
  input  wire logic [2:0]  v_range_i,
  input  wire logic [15:0] bat_mv_i,
  input  wire logic [15:0] adp_mv_i,
  output csl_cmp_s         cmp_o
);
  // Selector resistors seen as thermometer banks; the 2 percent gap gives hysteresis
  always_comb begin
    cmp_o.ilim_cmp = ~(3'h7 << i_range_i);
    cmp_o.vlim_cmp = ~(4'hF << v_range_i);
    cmp_o.batt_hi  = 32'(bat_mv_i) * 100 > 32'(adp_mv_i) * 89;
    cmp_o.batt_lo  = 32'(bat_mv_i) * 100 < 32'(adp_mv_i) * 87;
  end
endmodule : csl_analog_model

// [csl_limiter_tb_top.sv]
`timescale 1ns/1ps
`include "csl_params.svh"
module csl_limiter_tb_top import csl_pkg::*;;
  logic           clk_i = 1'b0, nrst_i = 1'b0, adp = 1'b0, inh = 1'b0;
  logic           wake = 1'b0, vwr = 1'b0, cwr = 1'b0, pf, cen;
  logic [1:0]     ir = 2'h0, irs;
  logic [2:0]     vr = 3'h0, vrs;
  logic [15:0]    bat = 16'h0, adc = 16'h0, vreq = 16'h0, creq = 16'h0;
  logic [16:0]    e;
  csl_chg_state_e st = CSL_CHG_RESET;
  csl_cmp_s       cmp;
  csl_out_s       dac;
  int             n_errors = 0, n_checks = 0, cnt;
  int ceil_mv[5] = '{`CSL_V_CEIL0_MV, `CSL_V_CEIL1_MV, `CSL_V_CEIL2_MV, `CSL_V_CEIL3_MV,
                     `CSL_V_CEIL4_MV};
  int ifs[4] = '{`CSL_I_FS0_MA, `CSL_I_FS1_MA, `CSL_I_FS2_MA, `CSL_I_FS3_MA};
  logic [15:0] vtab[4] = '{16'h07D0, 16'h1388, 16'h20F0, 16'hFFFF};
  csl_chg_state_e stab[5] = '{CSL_CHG_WAKE, CSL_CHG_WAKE, CSL_CHG_CONTROLLED, CSL_CHG_RESET,
                             CSL_CHG_NONE};
  initial forever #10 clk_i = ~clk_i;
  csl_analog_model model_u (.i_range_i(ir), .v_range_i(vr), .bat_mv_i(bat), .adp_mv_i(adc),
                            .cmp_o(cmp));
  csl_limiter #(.SLOW_CYCLES(8)) dut_u (.clk_i, .nrst_i, .cmp_i(cmp),
    .adapter_present_flag_i(adp), .chg_state_i(st), .inhibit_charge_i(inh), .wakeup_i(wake),
    .volt_wr_i(vwr), .requested_voltage_cmd_i(vreq), .curr_wr_i(cwr),
    .requested_current_cmd_i(creq), .dac_o(dac), .current_range_select_o(irs),
    .voltage_range_select_o(vrs), .battery_over_input_flag_o(pf), .charge_enable_out_o(cen));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Sample 1 ns after the edge so registered outputs have landed
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  task automatic wr(input logic v, input logic [15:0] d);
    @(posedge clk_i);
    if (v) {vwr, vreq} <= {1'b1, d}; else {cwr, creq} <= {1'b1, d};
    @(posedge clk_i);
    {vwr, cwr} <= 2'b00;
    tick(3);
  endtask : wr
  task automatic count_gate(input int n);
    cnt = 0;
    repeat (n) begin
      tick(1);
      if (dac.current_scale_gate === 1'b1) cnt++;
    end
  endtask : count_gate
  task automatic close_out();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    // Clamp, offset and quantise in every voltage range
    foreach (ceil_mv[r]) begin
      @(posedge clk_i);
      vr <= 3'(r);
      tick(3);
      check(16'(vrs), 16'(r));
      foreach (vtab[k]) begin
        wr(1'b1, vtab[k]);
        e = (vtab[k] < 16'h09A1) ? 17'h0 : {vtab[k] > ceil_mv[r],
            16'((vtab[k] > ceil_mv[r] ? ceil_mv[r] : vtab[k]) - 2465) & ~16'(r < 2 ? 15 : 31)};
        check(dac.volt_dac, e[15:0]);
        check(16'(dac.volt_overrange), 16'(e[16]));
      end
    end
    $display("test voltage done");
    // Low-current threshold and gated pulses per range, then the 80 percent duty ceiling in range 3
    foreach (ifs[r]) begin
      @(posedge clk_i);
      ir <= 2'(r);
      wr(1'b0, 16'(ifs[r] / 16 - 1));
      check(16'(irs), 16'(r));
      check(16'(dac.low_current_mode), 16'h1);
      count_gate(128);
      check(16'(cnt >= 4 && cnt <= 12), 16'h1);
      wr(1'b0, 16'(ifs[r] / 8));
      check(16'(dac.low_current_mode), 16'h0);
    end
    wr(1'b0, 16'hFFFF);
    count_gate(200);
    check(16'(cnt >= 155 && cnt <= 161), 16'h1);
    @(posedge clk_i);
    wake <= 1'b1;
    tick(3);
    check(16'(dac.low_current_mode), 16'h1);
    @(posedge clk_i);
    ir <= 2'h0;
    tick(3);
    check(16'(dac.low_current_mode), 16'h0);
    @(posedge clk_i);
    wake <= 1'b0;
    $display("test current done");
    // Power-fail with hysteresis, then adapter removal
    @(posedge clk_i);
    {adp, adc} <= {1'b1, 16'h2710};
    foreach (vtab[k]) begin
      @(posedge clk_i);
      bat <= k[1:0] == 2'h1 ? 16'h2260 : k[1:0] == 2'h2 ? 16'h2134 : 16'h2328;
      tick(3);
      check(16'(pf), 16'(k != 2));
    end
    @(posedge clk_i);
    adp <= 1'b0;
    tick(3);
    check(16'(pf), 16'h0);
    $display("test power fail done");
    // Charge enable per state; stored request is non-zero here
    foreach (stab[k]) begin
      @(posedge clk_i);
      st  <= stab[k];
      inh <= (k == 1);
      tick(3);
      check(16'(cen), 16'(k == 0 || k == 2));
    end
    @(posedge clk_i);
    st <= CSL_CHG_CONTROLLED;
    wr(1'b1, 16'h0000);
    check(16'(cen), 16'h0);
    $display("test enable done");
    close_out();
  end
endmodule : csl_limiter_tb_top
